// File: dv/rac_alarm_ctrl_assertions.sv
// rac_alarm_ctrl_assertions: port checks of the alarm and control block.
// assumes binding into rac_alarm_ctrl; all checks on sys_clk.
`timescale 1ns/1ps
module rac_alarm_ctrl_assertions #(
  parameter int unsigned FORCE_TEMP_CONVERSION_HOLDOFF = 20
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic osc_clk,
  input wire logic power_on_battery,
  input wire rac_pkg::rac_reg_req_t reg_req,
  input wire logic [7:0] reg_rdata,
  input wire rac_pkg::rac_time_t osc_time,
  input wire logic osc_sec_tick,
  input wire logic temp_force_temp_conversion_done,
  input wire logic temp_force_temp_conversion_req,
  input wire logic osc_run,
  input wire logic crystal_clock_output,
  input wire logic irq_or_wave_pin_o,
  input wire logic irq_or_wave_pin_oe
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);
  logic [7:0] ctl_q;
  logic rd_w;
  logic clr_w;
  assign rd_w = reg_req.strobe && !reg_req.addr[7];
  assign clr_w = reg_req.strobe && reg_req.addr == 8'h8f
    && reg_req.wdata[1:0] == 2'b00;
  // control shadow
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctl_q <= rac_pkg::CONTROL_RESET;
    end else if (reg_req.strobe && reg_req.addr == 8'h8e) begin
      ctl_q <= reg_req.wdata & rac_pkg::CONTROL_WR_MASK;
    end
  end
  pin_open_drain_a: assert property (irq_or_wave_pin_o == 1'b0)
    else $error("pin level not zero");
  unmapped_read_a: assert property (rd_w && reg_req.addr[6:0] > 7'h0f
    |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  rdata_hold_a: assert property (!rd_w |=> $stable(reg_rdata))
    else $error("read data moved");
  force_temp_conversion_start_a: assert property (reg_req.strobe && reg_req.addr == 8'h8e
    && reg_req.wdata[5] && !temp_force_temp_conversion_req |=> temp_force_temp_conversion_req)
    else $error("conversion not started");
  force_temp_conversion_hold_a: assert property ((temp_force_temp_conversion_req && !temp_force_temp_conversion_done)[*4]
    |=> temp_force_temp_conversion_req) else $error("conversion ended early");
  force_temp_conversion_end_a: assert property ($rose(temp_force_temp_conversion_done) && temp_force_temp_conversion_req
    |-> ##[1:5] !temp_force_temp_conversion_req) else $error("conversion not ended");
  pin_release_a: assert property (clr_w && ctl_q[2]
    |-> ##2 !irq_or_wave_pin_oe) else $error("pin not released");
  pin_quiet_a: assert property ((ctl_q[2] && ctl_q[1:0] == 2'b00)[*3]
    |-> !irq_or_wave_pin_oe) else $error("pin low while disabled");
  osc_main_a: assert property (!power_on_battery[*4] |-> osc_run)
    else $error("oscillator stopped on main");
  osc_dis_a: assert property (!osc_run |-> ctl_q[7] || $past(ctl_q[7]))
    else $error("oscillator stopped while enabled");
endmodule

bind rac_alarm_ctrl rac_alarm_ctrl_assertions #(
  .FORCE_TEMP_CONVERSION_HOLDOFF(FORCE_TEMP_CONVERSION_HOLDOFF)
) rac_alarm_ctrl_assertions_i (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .osc_clk(osc_clk),
  .power_on_battery(power_on_battery), .reg_req(reg_req),
  .reg_rdata(reg_rdata), .osc_time(osc_time),
  .osc_sec_tick(osc_sec_tick), .temp_force_temp_conversion_done(temp_force_temp_conversion_done),
  .temp_force_temp_conversion_req(temp_force_temp_conversion_req), .osc_run(osc_run),
  .crystal_clock_output(crystal_clock_output),
  .irq_or_wave_pin_o(irq_or_wave_pin_o),
  .irq_or_wave_pin_oe(irq_or_wave_pin_oe)
);

// File: dv/rac_host.sv
// rac_host: host model issuing single register accesses.
// assumes the bench calls acc between sys_clk edges.
`timescale 1ns/1ps
module rac_host (
  input wire logic sys_clk,
  output rac_pkg::rac_reg_req_t req,
  input wire logic [7:0] rdata
);
  initial req = '0;
  // one strobe, then scrambled idle lines, then read data
  task automatic acc(input logic w, input logic [6:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    @(negedge sys_clk);
    req <= '{1'b1, {w, a}, d};
    @(negedge sys_clk);
    req <= '{1'b0, ~{w, a}, ~d};
    @(negedge sys_clk);
    q = rdata;
  endtask
endmodule

// File: dv/tb_top.sv
// tb_top: self-checking bench for rac_alarm_ctrl with a host model.
// assumes the checker binds itself; oscillator period scaled to 160 ns.
`timescale 1ns/1ps
module tb_top;
  logic sys_clk, sys_rst, osc_clk, power_on_battery;
  logic osc_sec_tick, temp_force_temp_conversion_done, temp_force_temp_conversion_req, osc_run;
  logic clk_out, pin_o, pin_oe;
  rac_pkg::rac_reg_req_t reg_req;
  rac_pkg::rac_time_t osc_time, t;
  logic [7:0] reg_rdata, q;
  logic [31:0] r;
  logic [31:0] seed = 32'h225d50a6;
  int n_errors = 0, checks_done = 0, n_ticks = 0, cyc = 0, ns, nc;
  localparam logic [7:0] TCTL [5] = '{8'h08, 8'h10, 8'h18, 8'h18, 8'h58};
  localparam logic [7:0] TST [5] = '{8'h48, 8'h48, 8'h40, 8'h08, 8'h48};
  localparam int TSQ [5] = '{8, 32, 64, 0, 64};
  localparam int TCK [5] = '{256, 256, 0, 0, 256};

  rac_alarm_ctrl #(.FORCE_TEMP_CONVERSION_HOLDOFF(20)) rac_alarm_ctrl_i (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .osc_clk(osc_clk),
    .power_on_battery(power_on_battery), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .osc_time(osc_time),
    .osc_sec_tick(osc_sec_tick), .temp_force_temp_conversion_done(temp_force_temp_conversion_done),
    .temp_force_temp_conversion_req(temp_force_temp_conversion_req), .osc_run(osc_run),
    .crystal_clock_output(clk_out), .irq_or_wave_pin_o(pin_o),
    .irq_or_wave_pin_oe(pin_oe)
  );
  rac_host rac_host_i (.sys_clk(sys_clk), .req(reg_req), .rdata(reg_rdata));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // oscillator stands still while stopped
  initial begin
    osc_clk = 1'b0;
    #37;
    forever #80 osc_clk = osc_run ? ~osc_clk : 1'b0;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      end_sim();
    end
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [6:0] alv(input int j, input int a);
    case (j)
      0: return t.seconds;
      1: return t.minutes;
      2: return t.hours;
      default: return a ? {1'b0, t.date} : {4'h8, t.weekday};
    endcase
  endfunction
  function automatic rac_pkg::rac_time_t alt(input int f);
    rac_pkg::rac_time_t x;
    x = t;
    case (f)
      0: x.seconds ^= 7'h01;
      1: x.minutes ^= 7'h01;
      2: x.hours ^= 7'h01;
      default: x.date ^= 6'h01;
    endcase
    if (f == 3) x.weekday ^= 3'h1;
    return x;
  endfunction
  function automatic int nr(input int n, input int e);
    return (n >= e - 1 && n <= e + 1) ? e : n;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("errors=%0d checks=%0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] x;
    rac_host_i.acc(1'b1, a, d, x);
  endtask
  task automatic rc(input logic [6:0] a, input logic [7:0] m,
                    input logic [7:0] e);
    rac_host_i.acc(1'b0, a, 8'h00, q);
    chk(32'(q & m), 32'(e));
  endtask
  task automatic tick(input rac_pkg::rac_time_t v);
    @(negedge osc_clk);
    osc_time <= v;
    osc_sec_tick <= 1'b1;
    @(negedge osc_clk);
    osc_sec_tick <= 1'b0;
    n_ticks++;
    repeat (10) @(negedge sys_clk);
  endtask
  task automatic fin();
    @(negedge sys_clk);
    temp_force_temp_conversion_done = 1'b1;
    for (int i = 0; i < 20 && temp_force_temp_conversion_req; i++) @(negedge sys_clk);
    temp_force_temp_conversion_done = 1'b0;
  endtask
  task automatic meas();
    logic ls, lc;
    ns = 0;
    nc = 0;
    repeat (200) @(negedge sys_clk);
    ls = pin_oe;
    lc = clk_out;
    repeat (1638) begin
      @(negedge sys_clk);
      ns += int'(pin_oe && !ls);
      nc += int'(clk_out && !lc);
      ls = pin_oe;
      lc = clk_out;
    end
  endtask

  initial begin
    sys_rst = 1'b1;
    power_on_battery = 1'b0;
    osc_time = '0;
    osc_sec_tick = 1'b0;
    temp_force_temp_conversion_done = 1'b0;
    repeat (4) @(negedge sys_clk);
    sys_rst = 1'b0;
    rc(7'h0e, 8'hff, 8'h1c);
    rc(7'h0f, 8'hff, 8'hc8);
    wr(7'h0f, 8'hcf);
    rc(7'h0f, 8'hff, 8'hc8);
    wr(7'h0f, 8'h48);
    rc(7'h0f, 8'hff, 8'h48);
    // each alarm through every mask depth
    for (int a = 0; a < 2; a++) begin
      wr(7'h0e, a ? 8'h18 : 8'h1f);
      for (int k = 0; k <= 4 - a; k++) begin
        r = rnd();
        t = r[29:0];
        if (a == 1) t.seconds = 7'h00;
        for (int i = 0; i < 4 - a; i++)
          wr(7'(7 + 4 * a + i), {i >= k, alv(i + a, a)});
        wr(7'h0f, 8'h48);
        if (k + a > 0) begin
          tick(alt(k + a - 1));
          rc(7'h0f, 8'h01 << a, 8'h00);
        end
        tick(k + a < 4 ? alt(k + a) : t);
        rc(7'h0f, 8'h01 << a, 8'h01 << a);
        if (a == 0) chk(pin_oe, 1'b1);
        wr(7'h0f, 8'h48);
        repeat (2) @(negedge sys_clk);
        if (a == 0) chk(pin_oe, 1'b0);
      end
    end
    wr(7'h0e, 8'h3c);
    rc(7'h0e, 8'h20, 8'h20);
    rc(7'h0f, 8'h04, 8'h00);
    repeat (25) @(negedge sys_clk);
    rc(7'h0f, 8'h04, 8'h04);
    wr(7'h0e, 8'h1c);
    rc(7'h0e, 8'h20, 8'h20);
    fin();
    rc(7'h0e, 8'h20, 8'h00);
    rc(7'h0f, 8'h04, 8'h00);
    for (int i = 0; i < 200 && !temp_force_temp_conversion_req; i++) tick(t);
    chk(n_ticks, 64);
    rc(7'h0f, 8'h04, 8'h04);
    fin();
    wr(7'h0f, 8'h58);
    for (int i = 0; i < 200 && !temp_force_temp_conversion_req; i++) tick(t);
    chk(n_ticks, 64 + 128);
    fin();
    for (int i = 0; i < 5; i++) begin
      power_on_battery = i >= 3;
      wr(7'h0e, TCTL[i]);
      wr(7'h0f, TST[i]);
      meas();
      chk(nr(ns, TSQ[i]), TSQ[i]);
      chk(nr(nc, TCK[i]), TCK[i]);
    end
    wr(7'h0e, 8'h9c);
    repeat (4) @(negedge sys_clk);
    chk(osc_run, 1'b0);
    repeat (4500) @(negedge sys_clk);
    rc(7'h0f, 8'h80, 8'h80);
    power_on_battery = 1'b0;
    repeat (5) @(negedge sys_clk);
    chk(osc_run, 1'b1);
    rc(7'h0f, 8'h80, 8'h80);
    // let the restarted oscillator end the stall before clearing
    repeat (10) @(negedge sys_clk);
    wr(7'h0f, 8'h48);
    rc(7'h0f, 8'h80, 8'h00);
    rc(7'h1f, 8'hff, 8'h00);
    end_sim();
  end
endmodule

// File: verilog/rac_alarm_ctrl.sv
// rac_alarm_ctrl: alarms, interrupt/square-wave pin, oscillator control,
// clock output and temperature-conversion control of a real-time clock.
// assumes register strobes arrive on sys_clk from the serial framing logic,
// and the timekeeper presents time and a seconds tick on osc_clk.
`timescale 1ns/1ps

// Operation
// - alarm one at 07h-0Ah, alarm two 0Bh-0Dh
// - bit 7 masks a field; none masked exact match
// - bit 6 picks weekday, else date of month
// - alarm one masks select second to date matching
// - alarm two masks select minute to date matching
// - alarms evaluated on each seconds update
// - flags set regardless of interrupt control bits
// - pin low while enabled flag set, irq mode
// - flags cleared only by writing zero
// - irq select zero outputs square wave
// - rate bits pick 1Hz to 8.192kHz
// - on battery, wave needs enable, else released
// - oscillator stops only on battery when disabled
// - convert bit starts if idle, clears at end
// - user conversion leaves busy alone about 2ms
// - user conversion keeps automatic interval timing
// - rate bits pick 64 to 512 second interval
// - busy high while sensor converts; user ones set it only after holdoff
// - stop flag set on stop, held until cleared
// - clock output enable drives 32.768kHz or low
// - battery clock output disable forces output low
// - reset values 00011100 and 11001000
module rac_alarm_ctrl #(
  parameter int unsigned FORCE_TEMP_CONVERSION_HOLDOFF = rac_pkg::FORCE_TEMP_CONVERSION_HOLDOFF_CYCLES
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic osc_clk,
  input wire logic power_on_battery,
  input wire rac_pkg::rac_reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  input wire rac_pkg::rac_time_t osc_time,
  input wire logic osc_sec_tick,
  input wire logic temp_force_temp_conversion_done,
  output logic temp_force_temp_conversion_req,
  output logic osc_run,
  output logic crystal_clock_output,
  output logic irq_or_wave_pin_o,
  output logic irq_or_wave_pin_oe
);

  // ---------------- oscillator domain ----------------
  logic [1:0] osc_rst_q;
  logic osc_rst;
  rac_pkg::rac_time_t snap_q;
  logic tick_tog_q;
  logic [rac_pkg::DIV_W-1:0] div_q;
  logic [1:0] rs_meta_q;
  logic [1:0] rs_q;
  logic wave_q;
  logic [1:0] ctl_rate;

  // reset released into oscillator domain on its own edge
  always_ff @(posedge osc_clk or posedge sys_rst) begin
    if (sys_rst) begin
      osc_rst_q <= 2'h3;
    end else begin
      osc_rst_q <= {osc_rst_q[0], 1'b0};
    end
  end
  assign osc_rst = osc_rst_q[1];

  // time snapshot held a full second, tick crossed as a toggle
  always_ff @(posedge osc_clk or posedge osc_rst) begin
    if (osc_rst) begin
      snap_q <= '0;
      tick_tog_q <= 1'b0;
    end else if (osc_sec_tick) begin
      snap_q <= osc_time;
      tick_tog_q <= ~tick_tog_q;
    end
  end

  always_ff @(posedge osc_clk or posedge osc_rst) begin
    if (osc_rst) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  always_ff @(posedge osc_clk or posedge osc_rst) begin
    if (osc_rst) begin
      rs_meta_q <= 2'h3;
      rs_q <= 2'h3;
    end else begin
      rs_meta_q <= ctl_rate;
      rs_q <= rs_meta_q;
    end
  end

  // square-wave rate select
  always_ff @(posedge osc_clk or posedge osc_rst) begin
    if (osc_rst) begin
      wave_q <= 1'b0;
    end else begin
      unique case (rs_q)
        2'h0: wave_q <= div_q[rac_pkg::TAP_1HZ];
        2'h1: wave_q <= div_q[rac_pkg::TAP_1K];
        2'h2: wave_q <= div_q[rac_pkg::TAP_4K];
        2'h3: wave_q <= div_q[rac_pkg::TAP_8K];
      endcase
    end
  end

  // ---------------- system domain: synchronisers ----------------
  logic [2:0] tick_s_q;
  logic [1:0] wave_s_q;
  logic [2:0] oscs_q;
  logic [1:0] bat_s_q;
  logic [2:0] done_s_q;
  logic sec_event;
  logic osc_edge;
  logic done_rise;
  logic on_bat;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tick_s_q <= 3'h0;
      wave_s_q <= 2'h0;
      oscs_q <= 3'h0;
      bat_s_q <= 2'h0;
      done_s_q <= 3'h0;
    end else begin
      tick_s_q <= {tick_s_q[1:0], tick_tog_q};
      wave_s_q <= {wave_s_q[0], wave_q};
      oscs_q <= {oscs_q[1:0], osc_clk};
      bat_s_q <= {bat_s_q[0], power_on_battery};
      done_s_q <= {done_s_q[1:0], temp_force_temp_conversion_done};
    end
  end

  assign sec_event = tick_s_q[2] ^ tick_s_q[1];
  assign osc_edge = oscs_q[2] ^ oscs_q[1];
  assign done_rise = done_s_q[1] & ~done_s_q[2];
  assign on_bat = bat_s_q[1];

  // ---------------- register access ----------------
  logic wr;
  logic rd;
  logic [6:0] idx;
  logic [6:0] aoff;
  logic [7:0] alarm_q [rac_pkg::ALARM_REGS];
  logic [7:0] ctl_q;
  logic [7:0] stat_q;
  logic force_temp_conversion_q;
  logic busy_q;
  logic osf_q;
  logic a1f_q;
  logic a2f_q;
  logic wr_status;

  assign wr = reg_req.strobe & reg_req.addr[rac_pkg::ADDR_WRITE_BIT];
  assign rd = reg_req.strobe & ~reg_req.addr[rac_pkg::ADDR_WRITE_BIT];
  assign idx = reg_req.addr[6:0];
  assign aoff = idx - rac_pkg::ADDR_ALARM1_SEC;
  assign wr_status = wr && (idx == rac_pkg::ADDR_STATUS);
  assign ctl_rate = {ctl_q[rac_pkg::CTL_RS_HI], ctl_q[rac_pkg::CTL_RS_LO]};

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < rac_pkg::ALARM_REGS; i++) begin
        alarm_q[i] <= rac_pkg::ALARM_RESET;
      end
    end else if (wr && idx >= rac_pkg::ADDR_ALARM1_SEC &&
                 idx <= rac_pkg::ADDR_ALARM2_DAYDATE) begin
      alarm_q[aoff[2:0]] <= reg_req.wdata;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctl_q <= rac_pkg::CONTROL_RESET & rac_pkg::CONTROL_WR_MASK;
    end else if (wr && idx == rac_pkg::ADDR_CONTROL) begin
      ctl_q <= reg_req.wdata & rac_pkg::CONTROL_WR_MASK;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stat_q <= rac_pkg::STATUS_RESET & rac_pkg::STATUS_CFG_MASK;
    end else if (wr_status) begin
      stat_q <= reg_req.wdata & rac_pkg::STATUS_CFG_MASK;
    end
  end

  // ---------------- alarm matching ----------------
  function automatic logic dd_hit(logic [7:0] r, rac_pkg::rac_time_t t);
    if (r[rac_pkg::WEEKDAY_BIT]) begin
      dd_hit = (r[5:0] == {3'h0, t.weekday});
    end else begin
      dd_hit = (r[5:0] == t.date);
    end
  endfunction

  logic match1;
  logic match2;

  // masked fields always agree; all clear needs every field
  assign match1 = (alarm_q[0][rac_pkg::MASK_BIT] |
                   (alarm_q[0][6:0] == snap_q.seconds)) &
                  (alarm_q[1][rac_pkg::MASK_BIT] |
                   (alarm_q[1][6:0] == snap_q.minutes)) &
                  (alarm_q[2][rac_pkg::MASK_BIT] |
                   (alarm_q[2][6:0] == snap_q.hours)) &
                  (alarm_q[3][rac_pkg::MASK_BIT] |
                   dd_hit(alarm_q[3], snap_q));

  assign match2 = (snap_q.seconds == 7'h00) &
                  (alarm_q[4][rac_pkg::MASK_BIT] |
                   (alarm_q[4][6:0] == snap_q.minutes)) &
                  (alarm_q[5][rac_pkg::MASK_BIT] |
                   (alarm_q[5][6:0] == snap_q.hours)) &
                  (alarm_q[6][rac_pkg::MASK_BIT] |
                   dd_hit(alarm_q[6], snap_q));

  // flags: set wins over a clearing write; writing one keeps value
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      a1f_q <= 1'b0;
      a2f_q <= 1'b0;
    end else begin
      a1f_q <= (sec_event & match1) |
               (a1f_q & ~(wr_status & ~reg_req.wdata[rac_pkg::ST_A1F]));
      a2f_q <= (sec_event & match2) |
               (a2f_q & ~(wr_status & ~reg_req.wdata[rac_pkg::ST_A2F]));
    end
  end

  // ---------------- oscillator control and stop flag ----------------
  logic [12:0] stall_cnt_q;
  logic stalled;

  assign stalled = (stall_cnt_q == 13'(rac_pkg::OSC_STOP_CYCLES));

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stall_cnt_q <= '0;
    end else if (osc_edge) begin
      stall_cnt_q <= '0;
    end else if (!stalled) begin
      stall_cnt_q <= stall_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      osf_q <= 1'b1;
    end else begin
      osf_q <= stalled |
               (osf_q & ~(wr_status & ~reg_req.wdata[rac_pkg::ST_OSF]));
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      osc_run <= 1'b1;
    end else begin
      osc_run <= ~(ctl_q[rac_pkg::CTL_OSC_DIS] & on_bat);
    end
  end

  // ---------------- temperature conversion ----------------
  rac_pkg::rac_force_temp_conversion_state_t force_temp_conversion_st_q;
  logic [9:0] secs_q;
  logic [9:0] interval;
  logic auto_pend_q;
  logic [19:0] hold_q;
  logic user_req;

  assign interval = rac_pkg::FORCE_TEMP_CONVERSION_INTERVAL_BASE_S <<
                    {stat_q[rac_pkg::ST_CRATE_HI], stat_q[rac_pkg::ST_CRATE_LO]};
  assign user_req = wr && (idx == rac_pkg::ADDR_CONTROL) &&
                    reg_req.wdata[rac_pkg::CTL_FORCE_TEMP_CONVERSION] &&
                    (force_temp_conversion_st_q == rac_pkg::RAC_CV_IDLE);

  // automatic interval runs on seconds only, untouched by user requests
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      secs_q <= '0;
    end else if (sec_event) begin
      if (secs_q >= interval - 1'b1) begin
        secs_q <= '0;
      end else begin
        secs_q <= secs_q + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      force_temp_conversion_st_q <= rac_pkg::RAC_CV_IDLE;
      force_temp_conversion_q <= 1'b0;
      busy_q <= 1'b0;
      temp_force_temp_conversion_req <= 1'b0;
      auto_pend_q <= 1'b0;
      hold_q <= '0;
    end else begin
      if (sec_event && secs_q >= interval - 1'b1) begin
        auto_pend_q <= 1'b1;
      end
      unique case (force_temp_conversion_st_q)
        rac_pkg::RAC_CV_IDLE: begin
          if (user_req) begin
            force_temp_conversion_st_q <= rac_pkg::RAC_CV_RUN;
            force_temp_conversion_q <= 1'b1;
            temp_force_temp_conversion_req <= 1'b1;
            hold_q <= '0;
          end else if (auto_pend_q) begin
            force_temp_conversion_st_q <= rac_pkg::RAC_CV_RUN;
            auto_pend_q <= 1'b0;
            busy_q <= 1'b1;
            temp_force_temp_conversion_req <= 1'b1;
          end
        end
        rac_pkg::RAC_CV_RUN: begin
          if (force_temp_conversion_q && !busy_q) begin
            hold_q <= hold_q + 1'b1;
            if (hold_q == 20'(FORCE_TEMP_CONVERSION_HOLDOFF - 1)) begin
              busy_q <= 1'b1;
            end
          end
          if (done_rise) begin
            force_temp_conversion_st_q <= rac_pkg::RAC_CV_IDLE;
            force_temp_conversion_q <= 1'b0;
            busy_q <= 1'b0;
            temp_force_temp_conversion_req <= 1'b0;
          end
        end
      endcase
    end
  end

  // ---------------- read data ----------------
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (rd) begin
      if (idx >= rac_pkg::ADDR_ALARM1_SEC &&
          idx <= rac_pkg::ADDR_ALARM2_DAYDATE) begin
        reg_rdata <= alarm_q[aoff[2:0]];
      end else if (idx == rac_pkg::ADDR_CONTROL) begin
        reg_rdata <= ctl_q | ({7'h00, force_temp_conversion_q} << rac_pkg::CTL_FORCE_TEMP_CONVERSION);
      end else if (idx == rac_pkg::ADDR_STATUS) begin
        reg_rdata <= stat_q |
                     ({7'h00, osf_q} << rac_pkg::ST_OSF) |
                     ({7'h00, busy_q} << rac_pkg::ST_BUSY) |
                     ({7'h00, a2f_q} << rac_pkg::ST_A2F) |
                     ({7'h00, a1f_q} << rac_pkg::ST_A1F);
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

  // ---------------- pins ----------------
  logic irq_active;
  logic irq_output_select;

  assign irq_output_select = ctl_q[rac_pkg::CTL_IRQ_OUTPUT_SELECT];
  assign irq_active = (a1f_q & ctl_q[rac_pkg::CTL_ALARM_ONE_IRQ_ENABLE]) |
                      (a2f_q & ctl_q[rac_pkg::CTL_ALARM_TWO_IRQ_ENABLE]);

  // open drain: only ever pulls low
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_or_wave_pin_o <= 1'b0;
      irq_or_wave_pin_oe <= 1'b0;
    end else begin
      irq_or_wave_pin_o <= 1'b0;
      if (irq_output_select) begin
        irq_or_wave_pin_oe <= irq_active;
      end else if (on_bat && !ctl_q[rac_pkg::CTL_BATTERY_SQUARE_WAVE_ENABLE]) begin
        irq_or_wave_pin_oe <= 1'b0;
      end else begin
        irq_or_wave_pin_oe <= ~wave_s_q[1];
      end
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      crystal_clock_output <= 1'b0;
    end else begin
      crystal_clock_output <= oscs_q[1] & stat_q[rac_pkg::ST_EN32K] &
                              (~on_bat | stat_q[rac_pkg::ST_BB32K]);
    end
  end

endmodule

// File: verilog/rac_pkg.sv
// rac_pkg: register map, field positions, reset values, timing counts
// and carrier types for the alarm and control logic.
// assumes a 40 MHz system clock and a 32.768 kHz oscillator clock.
package rac_pkg;

  // register indices; the top bit of an address byte marks a write
  localparam logic [6:0] ADDR_ALARM1_SEC = 7'h07;
  localparam logic [6:0] ADDR_ALARM1_DAYDATE = 7'h0a;
  localparam logic [6:0] ADDR_ALARM2_MIN = 7'h0b;
  localparam logic [6:0] ADDR_ALARM2_DAYDATE = 7'h0d;
  localparam logic [6:0] ADDR_CONTROL = 7'h0e;
  localparam logic [6:0] ADDR_STATUS = 7'h0f;
  localparam int ADDR_WRITE_BIT = 7;

  // alarm register fields
  localparam int MASK_BIT = 7;
  localparam int WEEKDAY_BIT = 6;
  localparam int ALARM_REGS = 7;
  localparam logic [7:0] ALARM_RESET = 8'h00;

  // rtc_control fields
  localparam int CTL_OSC_DIS = 7;
  localparam int CTL_BATTERY_SQUARE_WAVE_ENABLE = 6;
  localparam int CTL_FORCE_TEMP_CONVERSION = 5;
  localparam int CTL_RS_HI = 4;
  localparam int CTL_RS_LO = 3;
  localparam int CTL_IRQ_OUTPUT_SELECT = 2;
  localparam int CTL_ALARM_TWO_IRQ_ENABLE = 1;
  localparam int CTL_ALARM_ONE_IRQ_ENABLE = 0;
  localparam logic [7:0] CONTROL_RESET = 8'h1c;
  localparam logic [7:0] CONTROL_WR_MASK = 8'hdf;

  // rtc_control_status fields
  localparam int ST_OSF = 7;
  localparam int ST_BB32K = 6;
  localparam int ST_CRATE_HI = 5;
  localparam int ST_CRATE_LO = 4;
  localparam int ST_EN32K = 3;
  localparam int ST_BUSY = 2;
  localparam int ST_A2F = 1;
  localparam int ST_A1F = 0;
  localparam logic [7:0] STATUS_RESET = 8'hc8;
  localparam logic [7:0] STATUS_CFG_MASK = 8'h78;

  // timing
  localparam int CLK_HZ = 40_000_000;
  localparam int FORCE_TEMP_CONVERSION_HOLDOFF_US = 2000;
  localparam int FORCE_TEMP_CONVERSION_HOLDOFF_CYCLES = FORCE_TEMP_CONVERSION_HOLDOFF_US * (CLK_HZ / 1_000_000);
  localparam int OSC_STOP_NS = 100_000;
  localparam int OSC_STOP_CYCLES = OSC_STOP_NS / (1_000_000_000 / CLK_HZ);
  localparam logic [9:0] FORCE_TEMP_CONVERSION_INTERVAL_BASE_S = 10'h040;

  // square-wave divider taps on the oscillator clock
  localparam int DIV_W = 15;
  localparam int TAP_1HZ = 14;
  localparam int TAP_1K = 4;
  localparam int TAP_4K = 2;
  localparam int TAP_8K = 1;

  typedef struct packed {
    logic [6:0] seconds;
    logic [6:0] minutes;
    logic [6:0] hours;
    logic [2:0] weekday;
    logic [5:0] date;
  } rac_time_t;

  typedef struct packed {
    logic strobe;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rac_reg_req_t;

  typedef enum logic {
    RAC_CV_IDLE,
    RAC_CV_RUN
  } rac_force_temp_conversion_state_t;

endpackage
